// File: rtl/mb_pkg.sv
`default_nettype none
package mb_pkg;
  localparam logic [15:0] TCP_PORT = 16'h01F6;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [15:0] LEN_EXC = 16'h0003;
  localparam logic [15:0] LEN_BASE = 16'h0003;
  localparam int AREA_BYTES = 512;
  localparam int MAX_QTY_DEF = 125;
  localparam logic [3:0] REQ_LAST = 4'hB;
  localparam logic [3:0] REQ_FULL = 4'hC;
  localparam logic [3:0] HDR_LAST = 4'h8;
  localparam logic [1:0] MEM_WAIT = 2'h2;
  localparam logic [3:0] IDX_TID_HI = 4'h0;
  localparam logic [3:0] IDX_TID_LO = 4'h1;
  localparam logic [3:0] IDX_UNIT = 4'h6;
  localparam logic [3:0] IDX_FC = 4'h7;
  localparam logic [3:0] IDX_START_HI = 4'h8;
  localparam logic [3:0] IDX_START_LO = 4'h9;
  localparam logic [3:0] IDX_QTY_HI = 4'hA;
  localparam logic [3:0] IDX_QTY_LO = 4'hB;

  typedef struct packed {
    logic [15:0] tid;
    logic [7:0] unit;
    logic [7:0] fc;
    logic [15:0] start;
    logic [15:0] qty;
  } req_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } beat_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RECV = 3'b001,
    S_CHECK = 3'b011,
    S_HDR = 3'b010,
    S_DATA = 3'b110,
    S_DROP = 3'b100
  } state_t;
endpackage
`default_nettype wire

// File: rtl/request_check.sv
`default_nettype none
module request_check import mb_pkg::*; #(
  parameter int MAX_QTY = MAX_QTY_DEF
) (
  input wire req_t req,
  input wire logic [9:0] in_size,
  input wire logic [9:0] out_size,
  output logic [7:0] code
);
  if (MAX_QTY < 1 || MAX_QTY > 125) begin : g_bad_qty
    $error("MAX_QTY out of range");
  end

  logic [16:0] end_reg;
  logic [8:0] area_regs;

  always_comb begin
    end_reg = {1'b0, req.start} + {1'b0, req.qty};
    area_regs = (req.fc == FC_RD_INPUT) ? in_size[9:1] : out_size[9:1];
    if (req.fc != FC_RD_INPUT && req.fc != FC_RD_HOLD) begin
      code = EXC_FUNC;
    end else if (req.qty == 16'h0000 || req.qty > 16'(MAX_QTY)) begin
      code = EXC_VALUE;
    end else if (end_reg > {8'h00, area_regs}) begin
      code = EXC_ADDR;
    end else begin
      code = EXC_NONE;
    end
  end
endmodule
`default_nettype wire

// File: rtl/modbus_ro_server.sv
// Overview of operation
// - requests are taken and answers sent only on tcp port 502.
// - both data areas are read only, served through a subset of standard function codes and addressing.
// - function 4 returns words from the input area at bytes 0x000 to 0x1FF.
// - function 3 returns words from the output area at bytes 0x200 to 0x3FF.
// - register n from 0 to 0xFF maps to bytes 2n and 2n+1 of the chosen area.
// - with the control/status word enabled, input register 0 is the status word and output register 0 the control word.
// - an unsupported function code gets exception 0x01.
// - registers beyond the initialized part of the area get exception 0x02.
// - an invalid register quantity gets exception 0x03.
// - the low byte of the control and status words sits in the first byte of its area.
`default_nettype none
module modbus_ro_server import mb_pkg::*; #(
  parameter int MAX_QTY = MAX_QTY_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire beat_t rx_beat,
  input wire logic [15:0] rx_port,
  output logic rx_ready,
  output logic tx_valid,
  output beat_t tx_beat,
  input wire logic tx_ready,
  output logic [15:0] tx_port,
  output logic [9:0] mem_addr,
  input wire logic [7:0] mem_data,
  input wire logic cs_enable,
  input wire logic [15:0] status_word,
  input wire logic [15:0] control_word,
  input wire logic [9:0] in_size,
  input wire logic [9:0] out_size
);
  if (MAX_QTY < 1 || MAX_QTY > 125) begin : g_bad_qty
    $error("MAX_QTY out of range");
  end

  // register value is {byte 2n+1, byte 2n}; high byte goes out first
  function automatic logic [9:0] area_addr(input logic [7:0] fc, input logic [7:0] rn, input logic lo);
    area_addr = {fc == FC_RD_HOLD, rn, ~lo};
  endfunction

  function automatic logic [7:0] hdr_byte(input logic [3:0] i, input req_t r, input logic [7:0] code);
    logic [15:0] len;
    len = (code != EXC_NONE) ? LEN_EXC : LEN_BASE + {r.qty[14:0], 1'b0};
    case (i)
      4'h0: hdr_byte = r.tid[15:8];
      4'h1: hdr_byte = r.tid[7:0];
      4'h2, 4'h3: hdr_byte = 8'h00;
      4'h4: hdr_byte = len[15:8];
      4'h5: hdr_byte = len[7:0];
      4'h6: hdr_byte = r.unit;
      4'h7: hdr_byte = (code != EXC_NONE) ? (r.fc | EXC_FLAG) : r.fc;
      default: hdr_byte = (code != EXC_NONE) ? code : {r.qty[6:0], 1'b0};
    endcase
  endfunction

  state_t state, next_state;
  req_t req;
  logic [3:0] rx_cnt;
  logic [7:0] exc_code;
  logic [7:0] chk_code;
  logic [3:0] hdr_idx;
  logic [7:0] cur_reg;
  logic [7:0] left;
  logic byte_lo;
  logic [1:0] rd_wait;
  logic rx_fire, tx_fire, is_exc, last_data;
  logic [15:0] cs_word;

  assign rx_fire = rx_valid && rx_ready;
  assign tx_fire = tx_valid && tx_ready;
  assign is_exc = exc_code != EXC_NONE;
  assign last_data = left == 8'h01 && byte_lo;
  assign cs_word = (req.fc == FC_RD_INPUT) ? status_word : control_word;

  request_check #(.MAX_QTY(MAX_QTY)) u_check (
    .req(req),
    .in_size(in_size),
    .out_size(out_size),
    .code(chk_code)
  );

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (rx_fire && !rx_beat.last) begin
          next_state = (rx_port == TCP_PORT) ? S_RECV : S_DROP;
        end
      end
      S_RECV: begin
        if (rx_fire && rx_beat.last) begin
          next_state = (rx_cnt >= REQ_LAST) ? S_CHECK : S_IDLE;
        end
      end
      S_DROP: begin
        if (rx_fire && rx_beat.last) begin
          next_state = S_IDLE;
        end
      end
      S_CHECK: next_state = S_HDR;
      S_HDR: begin
        if (tx_fire && hdr_idx == HDR_LAST) begin
          next_state = is_exc ? S_IDLE : S_DATA;
        end
      end
      S_DATA: begin
        if (tx_fire && last_data) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      rx_ready <= 1'b0;
      tx_port <= 16'h0000;
    end else begin
      state <= next_state;
      rx_ready <= next_state == S_IDLE || next_state == S_RECV || next_state == S_DROP;
      tx_port <= TCP_PORT;
    end
  end

  // request capture, bytes past the twelfth are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_cnt <= 4'h0;
      req <= '0;
    end else if (rx_fire && (state == S_IDLE || state == S_RECV)) begin
      rx_cnt <= (state == S_IDLE) ? 4'h1 : ((rx_cnt == REQ_FULL) ? REQ_FULL : rx_cnt + 4'h1);
      case ((state == S_IDLE) ? IDX_TID_HI : rx_cnt)
        IDX_TID_HI: req.tid[15:8] <= rx_beat.data;
        IDX_TID_LO: req.tid[7:0] <= rx_beat.data;
        IDX_UNIT: req.unit <= rx_beat.data;
        IDX_FC: req.fc <= rx_beat.data;
        IDX_START_HI: req.start[15:8] <= rx_beat.data;
        IDX_START_LO: req.start[7:0] <= rx_beat.data;
        IDX_QTY_HI: req.qty[15:8] <= rx_beat.data;
        IDX_QTY_LO: req.qty[7:0] <= rx_beat.data;
        default: req <= req;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      exc_code <= EXC_NONE;
    end else if (state == S_CHECK) begin
      exc_code <= chk_code;
    end
  end

  // read pointer into the area; memory answers one cycle after mem_addr
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_reg <= 8'h00;
      left <= 8'h00;
      byte_lo <= 1'b0;
      rd_wait <= 2'h0;
      mem_addr <= 10'h000;
    end else begin
      mem_addr <= area_addr(req.fc, cur_reg, byte_lo);
      if (state == S_CHECK) begin
        cur_reg <= req.start[7:0];
        left <= req.qty[7:0];
        byte_lo <= 1'b0;
        rd_wait <= MEM_WAIT;
      end else if (state == S_DATA && tx_fire) begin
        byte_lo <= ~byte_lo;
        rd_wait <= MEM_WAIT;
        if (byte_lo) begin
          cur_reg <= cur_reg + 8'h01;
          left <= left - 8'h01;
        end
      end else if (rd_wait != 2'h0) begin
        rd_wait <= rd_wait - 2'h1;
      end
    end
  end

  // byte output, one bubble cycle after every accepted header byte and three after every accepted data byte
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_beat <= '0;
      hdr_idx <= 4'h0;
    end else if (tx_fire) begin
      tx_valid <= 1'b0;
      hdr_idx <= (state == S_HDR) ? hdr_idx + 4'h1 : hdr_idx;
    end else if (state == S_CHECK) begin
      hdr_idx <= 4'h0;
    end else if (state == S_HDR && !tx_valid) begin
      tx_valid <= 1'b1;
      tx_beat.data <= hdr_byte(hdr_idx, req, exc_code);
      tx_beat.last <= is_exc && hdr_idx == HDR_LAST;
    end else if (state == S_DATA && !tx_valid && rd_wait == 2'h0) begin
      tx_valid <= 1'b1;
      if (cs_enable && cur_reg == 8'h00) begin
        tx_beat.data <= byte_lo ? cs_word[7:0] : cs_word[15:8];
      end else begin
        tx_beat.data <= mem_data;
      end
      tx_beat.last <= last_data;
    end
  end

  sequence s_req_done;
    state == S_CHECK;
  endsequence

  property p_port_out;
    @(posedge clk) disable iff (rst) tx_valid |-> tx_port == TCP_PORT;
  endproperty
  a_port_out: assert property (p_port_out) else $error("answer not on port 502");

  property p_port_in;
    @(posedge clk) disable iff (rst)
      state == S_IDLE && rx_fire && !rx_beat.last && rx_port != TCP_PORT |=> state == S_DROP;
  endproperty
  a_port_in: assert property (p_port_in) else $error("foreign port frame not dropped");

  property p_exc_func;
    @(posedge clk) disable iff (rst)
      s_req_done and req.fc != FC_RD_INPUT and req.fc != FC_RD_HOLD |=> exc_code == EXC_FUNC;
  endproperty
  a_exc_func: assert property (p_exc_func) else $error("bad function not 0x01");

  property p_exc_value;
    @(posedge clk) disable iff (rst)
      s_req_done and req.fc == FC_RD_INPUT and req.qty == 16'h0000 |=> exc_code == EXC_VALUE;
  endproperty
  a_exc_value: assert property (p_exc_value) else $error("zero quantity not 0x03");

  property p_exc_addr;
    @(posedge clk) disable iff (rst)
      s_req_done and req.fc == FC_RD_INPUT and req.qty == 16'h0001 and req.start[15:8] == 8'h00
      and req.start[7:0] >= in_size[9:1] |=> exc_code == EXC_ADDR;
  endproperty
  a_exc_addr: assert property (p_exc_addr) else $error("uninitialized register not 0x02");

  property p_exc_fc_flag;
    @(posedge clk) disable iff (rst)
      state == S_HDR && tx_valid && hdr_idx == IDX_FC && is_exc |-> tx_beat.data == (req.fc | EXC_FLAG);
  endproperty
  a_exc_fc_flag: assert property (p_exc_fc_flag) else $error("exception fc top bit missing");

  property p_tid_echo;
    @(posedge clk) disable iff (rst)
      state == S_HDR && tx_valid && hdr_idx == IDX_TID_HI |-> tx_beat.data == req.tid[15:8];
  endproperty
  a_tid_echo: assert property (p_tid_echo) else $error("transaction id not echoed");

  property p_area_in;
    @(posedge clk) disable iff (rst)
      state == S_DATA && req.fc == FC_RD_INPUT && rd_wait == 2'h0 |-> !mem_addr[9];
  endproperty
  a_area_in: assert property (p_area_in) else $error("input read left input area");

  property p_area_out;
    @(posedge clk) disable iff (rst)
      state == S_DATA && req.fc == FC_RD_HOLD && rd_wait == 2'h0 |-> mem_addr[9];
  endproperty
  a_area_out: assert property (p_area_out) else $error("holding read left output area");

  property p_reg_map;
    @(posedge clk) disable iff (rst)
      state == S_DATA && rd_wait == 2'h0 |-> mem_addr[8:1] == cur_reg && mem_addr[0] == !byte_lo;
  endproperty
  a_reg_map: assert property (p_reg_map) else $error("register to byte mapping wrong");

  property p_cs_word;
    @(posedge clk) disable iff (rst)
      state == S_DATA && $rose(tx_valid) && cs_enable && cur_reg == 8'h00 && !byte_lo && req.fc == FC_RD_INPUT
      |-> tx_beat.data == status_word[15:8];
  endproperty
  a_cs_word: assert property (p_cs_word) else $error("status word not on input register 0");
endmodule
`default_nettype wire

// File: tb/shared_mem.sv
`default_nettype none
module shared_mem (
  input wire logic clk,
  input wire logic [9:0] mem_addr,
  output logic [7:0] mem_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // contents depend on both area and offset so a misplaced read shows up
  always_ff @(posedge clk) begin
    mem_data <= mem_addr[7:0] ^ {4'h0, mem_addr[9:8], 2'h3};
  end
endmodule
`default_nettype wire

// File: tb/modbus_ro_server_bench.sv
`default_nettype none
module modbus_ro_server_bench import mb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MQ = 8;
  logic clk = 1'b0, rst = 1'b1, rx_valid = 1'b0, tx_ready = 1'b0, cs_enable = 1'b0, slow = 1'b0;
  logic rx_ready, tx_valid, lastok;
  beat_t rx_beat = '0;
  beat_t tx_beat;
  logic [15:0] rx_port = 16'h0000, status_word = 16'hA5C3, control_word = 16'h3C5A, tid = 16'h0000;
  logic [15:0] tx_port;
  logic [9:0] mem_addr, in_size = 10'h200, out_size = 10'h200;
  logic [7:0] mem_data;
  logic [7:0] exp[$], got[$];
  int fails = 0, checks = 0;

  always #10 clk = ~clk;

  modbus_ro_server #(.MAX_QTY(MQ)) modbus_ro_server_i (.clk(clk), .rst(rst), .rx_valid(rx_valid),
    .rx_beat(rx_beat), .rx_port(rx_port), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_beat(tx_beat),
    .tx_ready(tx_ready), .tx_port(tx_port), .mem_addr(mem_addr), .mem_data(mem_data),
    .cs_enable(cs_enable), .status_word(status_word), .control_word(control_word),
    .in_size(in_size), .out_size(out_size));
  shared_mem shared_mem_i (.clk(clk), .mem_addr(mem_addr), .mem_data(mem_data));

  function automatic logic [7:0] mem_at(input logic [9:0] a);
    return a[7:0] ^ {4'h0, a[9:8], 2'h3};
  endfunction

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic lst, input logic [15:0] port);
    int n;
    n = 0;
    while (rx_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n == 100) begin
      fails++;
      give_verdict();
    end
    rx_valid = 1'b1;
    rx_beat = '{data: b, last: lst};
    rx_port = port;
    @(negedge clk);
  endtask

  // one request frame, then collect and judge the whole answer
  task automatic xfer(input logic [7:0] fc, input logic [15:0] st, input logic [15:0] qty,
                      input logic [15:0] port, input logic [7:0] exc);
    logic [9:0] a;
    logic [15:0] w;
    logic [7:0] req[12];
    int n;
    tid = tid + 16'h0101;
    req = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h06, 8'h11, fc, st[15:8], st[7:0], qty[15:8], qty[7:0]};
    exp = {};
    got = {};
    if (port == TCP_PORT) begin
      exp = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, (exc != EXC_NONE) ? 8'h03 : 8'(3 + 2 * qty), 8'h11};
      if (exc != EXC_NONE) exp = {exp, fc | EXC_FLAG, exc};
      else begin
        exp = {exp, fc, 8'(2 * qty)};
        for (int r = 0; r < qty; r++) begin
          a = {fc == FC_RD_HOLD, 9'(2 * (st + r))};
          w = {mem_at(a + 10'h001), mem_at(a)};
          if (cs_enable && st + r == 0) w = (fc == FC_RD_HOLD) ? control_word : status_word;
          exp = {exp, w[15:8], w[7:0]};
        end
      end
    end
    @(negedge clk);
    foreach (req[i]) put(req[i], i == 11, port);
    rx_valid = 1'b0;
    lastok = 1'b1;
    for (n = 0; n < 400; n++) begin
      tx_ready = slow ? n[1] : 1'b1;
      if (tx_valid === 1'b1 && tx_ready) begin
        got.push_back(tx_beat.data);
        if (tx_beat.last !== (got.size() == exp.size())) lastok = 1'b0;
        if (tx_beat.last === 1'b1) break;
      end
      @(negedge clk);
    end
    if (n == 400 && exp.size() > 0) begin
      fails++;
      give_verdict();
    end
    chk("answer length", 16'(exp.size()), 16'(got.size()));
    foreach (exp[i]) if (i < got.size()) chk("answer byte", 16'(exp[i]), 16'(got[i]));
    chk("last flag", 16'h0001, 16'(lastok));
  endtask

  task automatic t_read_input();
    xfer(FC_RD_INPUT, 16'h0000, 16'h0002, TCP_PORT, EXC_NONE);
    xfer(FC_RD_INPUT, 16'h00FE, 16'h0002, TCP_PORT, EXC_NONE);
    chk("tx port", TCP_PORT, tx_port);
    $display("test read_input done");
  endtask

  task automatic t_read_hold();
    slow = 1'b1;
    xfer(FC_RD_HOLD, 16'h0010, 16'(MQ), TCP_PORT, EXC_NONE);
    xfer(FC_RD_HOLD, 16'h00F8, 16'(MQ), TCP_PORT, EXC_NONE);
    slow = 1'b0;
    $display("test read_hold done");
  endtask

  task automatic t_cs_word();
    cs_enable = 1'b1;
    xfer(FC_RD_INPUT, 16'h0000, 16'h0002, TCP_PORT, EXC_NONE);
    xfer(FC_RD_HOLD, 16'h0000, 16'h0001, TCP_PORT, EXC_NONE);
    cs_enable = 1'b0;
    $display("test cs_word done");
  endtask

  task automatic t_bad_func();
    logic [7:0] codes[8];
    codes = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h17, 8'h2B};
    foreach (codes[i]) xfer(codes[i], 16'h0000, 16'h0001, TCP_PORT, EXC_FUNC);
    xfer(FC_RD_INPUT, 16'h0000, 16'h0001, TCP_PORT, EXC_NONE);
    $display("test bad_func done");
  endtask

  task automatic t_bad_qty();
    xfer(FC_RD_INPUT, 16'h0000, 16'h0000, TCP_PORT, EXC_VALUE);
    xfer(FC_RD_HOLD, 16'h0000, 16'(MQ + 1), TCP_PORT, EXC_VALUE);
    $display("test bad_qty done");
  endtask

  task automatic t_bad_addr();
    in_size = 10'h014;
    out_size = 10'h000;
    xfer(FC_RD_INPUT, 16'h0009, 16'h0002, TCP_PORT, EXC_ADDR);
    xfer(FC_RD_INPUT, 16'h0008, 16'h0002, TCP_PORT, EXC_NONE);
    xfer(FC_RD_INPUT, 16'h000A, 16'h0001, TCP_PORT, EXC_ADDR);
    xfer(FC_RD_HOLD, 16'h0000, 16'h0001, TCP_PORT, EXC_ADDR);
    in_size = 10'h200;
    out_size = 10'h200;
    $display("test bad_addr done");
  endtask

  task automatic t_port();
    xfer(FC_RD_INPUT, 16'h0000, 16'h0001, 16'h01F7, EXC_NONE);
    xfer(FC_RD_INPUT, 16'h0001, 16'h0001, TCP_PORT, EXC_NONE);
    $display("test port done");
  endtask

  // reset in mid-frame must clear the receive state and the rx_ready, tx_valid, tx_port and mem_addr outputs
  task automatic t_reset();
    for (int i = 0; i < 5; i++) put(8'h00, 1'b0, TCP_PORT);
    rx_valid = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("rx_ready in reset", 16'h0000, 16'(rx_ready));
    chk("tx_valid in reset", 16'h0000, 16'(tx_valid));
    chk("tx_port in reset", 16'h0000, tx_port);
    chk("mem_addr in reset", 16'h0000, 16'(mem_addr));
    rst = 1'b0;
    @(negedge clk);
    chk("rx_ready after reset", 16'h0001, 16'(rx_ready));
    chk("tx_port after reset", TCP_PORT, tx_port);
    xfer(FC_RD_INPUT, 16'h0003, 16'h0001, TCP_PORT, EXC_NONE);
    $display("test reset done");
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_read_input();
    t_read_hold();
    t_cs_word();
    t_bad_func();
    t_bad_qty();
    t_bad_addr();
    t_port();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
